// ==== rtl/epp_device.sv ====
`timescale 1ns/1ps
module epp_device #(
	parameter int AW = 6,
	parameter int AUTO_WORDS = 16
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	epp_if.device              pins,
	input  wire logic [1:0]    algorithm_select_i,
	input  wire logic [3:0]    slave_ack_pin_select_i,
	input  wire logic [AW-1:0] core_rd_addr_i,
	output logic [15:0]        core_rd_data_o,
	output logic               sys_rd_o,
	output logic               programming_active_o,
	output logic               program_result_o
);
	localparam int DEPTH = 1 << AW;
	localparam int AFLD_PAD = epp_pkg::AFLD_W - AW;
	typedef enum logic [3:0] {
		D_SETTLE, D_SLAVE, D_A_ADDR, D_A_RD, D_A_CMD, D_A_DATA, D_A_NEXT, D_DONE
	} epp_dst_t;
	epp_dst_t state_q;
	logic [15:0]   mem_q [DEPTH];
	logic [15:0]   bus1_q, bus2_q;
	logic          stb1_q, stb2_q, stb_prev_q;
	logic          lat1_q, lat2_q, ainc1_q, ainc2_q;
	logic [1:0]    alg1_q, alg2_q, alg_q;
	logic [3:0]    sid1_q, sid2_q;
	logic [4:0]    cnt_q, ack_cnt_q;
	logic [1:0]    cmd_q;
	logic          op_q, fail_q;
	logic [AW-1:0] addr_q, idx_q;
	logic [15:0]   data_q;
	logic          fall, rise;
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic          wr_ok;

	// Pins from outside: two flops before any logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus1_q <= epp_pkg::BUS_IDLE;
			bus2_q <= epp_pkg::BUS_IDLE;
			stb1_q <= 1'b1;
			stb2_q <= 1'b1;
			stb_prev_q <= 1'b1;
			lat1_q <= 1'b0;
			lat2_q <= 1'b0;
			ainc1_q <= 1'b1;
			ainc2_q <= 1'b1;
			alg1_q <= epp_pkg::ALG_SLAVE;
			alg2_q <= epp_pkg::ALG_SLAVE;
			sid1_q <= 4'h0;
			sid2_q <= 4'h0;
		end else if (ce_i) begin
			bus1_q <= pins.programming_bus;
			bus2_q <= bus1_q;
			stb1_q <= pins.program_strobe;
			stb2_q <= stb1_q;
			stb_prev_q <= stb2_q;
			lat1_q <= pins.program_address_latch;
			lat2_q <= lat1_q;
			ainc1_q <= pins.auto_increment_n;
			ainc2_q <= ainc1_q;
			alg1_q <= algorithm_select_i;
			alg2_q <= alg1_q;
			sid1_q <= slave_ack_pin_select_i;
			sid2_q <= sid1_q;
		end
	end

	assign fall = stb_prev_q && !stb2_q;
	assign rise = !stb_prev_q && stb2_q;

	// Cell write: slave program at rise, or auto data phase end
	always_comb begin
		wr_en = 1'b0;
		wr_addr = addr_q;
		if (state_q == D_SLAVE && rise && op_q && cmd_q == epp_pkg::CMD_PROGRAM) begin
			wr_en = 1'b1;
		end else if (state_q == D_A_DATA && cnt_q == 5'(epp_pkg::STROBE_LOW_CYC - 1)) begin
			wr_en = 1'b1;
			wr_addr = idx_q;
		end
		wr_ok = epp_pkg::program_strobe_ok(mem_q[wr_addr], data_q);
	end

	// Storage; reset models the erased array
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= epp_pkg::ERASED;
			core_rd_data_o <= epp_pkg::ERASED;
		end else if (ce_i) begin
			if (wr_en) mem_q[wr_addr] <= mem_q[wr_addr] & data_q;
			core_rd_data_o <= mem_q[core_rd_addr_i];
		end
	end

	// Mode sequencer: one sample of the select after reset settles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= D_SETTLE;
			alg_q <= epp_pkg::ALG_SLAVE;
			cnt_q <= 5'h00;
			idx_q <= '0;
			fail_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_q + 5'h01;
			case (state_q)
				D_SETTLE: if (cnt_q == 5'(epp_pkg::ALG_SETTLE_CYC - 1)) begin
					alg_q <= alg2_q;
					cnt_q <= 5'h00;
					state_q <= (alg2_q == epp_pkg::ALG_SLAVE) ? D_SLAVE : D_A_ADDR;
				end
				D_SLAVE: cnt_q <= 5'h00; // Select is never re-read here
				D_A_ADDR: begin
					cnt_q <= 5'h00;
					state_q <= D_A_RD;
				end
				D_A_RD: if (cnt_q == 5'(epp_pkg::SYS_RD_CYC + 1)) begin
					cnt_q <= 5'h00;
					state_q <= D_A_CMD;
				end
				D_A_CMD: if (cnt_q == 5'(epp_pkg::STROBE_LOW_CYC - 1)) begin
					cnt_q <= 5'h00;
					state_q <= D_A_DATA;
				end
				D_A_DATA: if (cnt_q == 5'(epp_pkg::STROBE_LOW_CYC - 1)) begin
					cnt_q <= 5'h00;
					fail_q <= fail_q | !wr_ok;
					state_q <= D_A_NEXT;
				end
				D_A_NEXT: if (cnt_q == 5'(epp_pkg::RECOVER_CYC - 1)) begin
					cnt_q <= 5'h00;
					idx_q <= idx_q + AW'(1);
					state_q <= (idx_q == AW'(AUTO_WORDS - 1)) ? D_DONE : D_A_ADDR;
				end
				default: cnt_q <= 5'h00;
			endcase
		end
	end

	// Slave command, address and data capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= epp_pkg::CMD_READ;
			addr_q <= '0;
			data_q <= epp_pkg::ERASED;
			op_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == D_SLAVE && fall && lat2_q) begin
				cmd_q <= bus2_q[epp_pkg::CMD_LSB +: epp_pkg::CMD_W];
				addr_q <= bus2_q[AW-1:0];
			end else if (state_q == D_SLAVE && fall) begin
				op_q <= 1'b1;
				data_q <= bus2_q;
			end else if (state_q == D_SLAVE && rise && op_q) begin
				op_q <= 1'b0;
				if (!ainc2_q) addr_q <= addr_q + AW'(1);
			end else if (state_q == D_A_RD && cnt_q == 5'(epp_pkg::SYS_RD_CYC + 1)) begin
				data_q <= bus2_q;
			end
		end
	end

	// Pin drive; slave side stays released but for replies
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins.dev_bus_o <= epp_pkg::BUS_IDLE;
			pins.dev_bus_oe <= 16'h0000;
			pins.dev_latch <= 1'b0;
			pins.dev_strobe_n <= 1'b1;
			pins.dev_verify <= 1'b1;
			ack_cnt_q <= 5'h00;
			sys_rd_o <= 1'b0;
			programming_active_o <= 1'b0;
			program_result_o <= 1'b0;
		end else if (ce_i) begin
			programming_active_o <= state_q != D_SLAVE && state_q != D_DONE && alg_q != epp_pkg::ALG_SLAVE;
			program_result_o <= (state_q == D_DONE) && fail_q;
			sys_rd_o <= state_q == D_A_RD && cnt_q < 5'(epp_pkg::SYS_RD_CYC);
			pins.dev_latch <= state_q == D_A_CMD;
			pins.dev_strobe_n <= !((state_q == D_A_CMD || state_q == D_A_DATA)
				&& cnt_q != 5'(epp_pkg::STROBE_LOW_CYC - 1));
			if (ack_cnt_q != 5'h00) ack_cnt_q <= ack_cnt_q - 5'h01;
			if (state_q == D_SLAVE && rise && op_q && cmd_q == epp_pkg::CMD_PROGRAM) begin
				pins.dev_verify <= wr_ok;
				pins.dev_bus_o <= {16{wr_ok}};
				pins.dev_bus_oe <= 16'h0001 << sid2_q;
				ack_cnt_q <= 5'(epp_pkg::ACK_HOLD_CYC);
			end else if (state_q == D_SLAVE && fall && !lat2_q && cmd_q == epp_pkg::CMD_READ) begin
				pins.dev_bus_o <= mem_q[addr_q];
				pins.dev_bus_oe <= 16'hFFFF;
			end else if (state_q == D_SLAVE && (rise || ack_cnt_q == 5'h01)) begin
				pins.dev_bus_o <= epp_pkg::BUS_IDLE;
				pins.dev_bus_oe <= 16'h0000;
			end else if (state_q == D_A_ADDR) begin
				pins.dev_bus_o <= epp_pkg::AUTO_SRC_BASE + 16'(idx_q);
				pins.dev_bus_oe <= 16'hFFFF;
			end else if (state_q == D_A_RD || state_q == D_A_NEXT) begin
				pins.dev_bus_o <= epp_pkg::BUS_IDLE;
				pins.dev_bus_oe <= 16'h0000;
			end else if (state_q == D_A_CMD) begin
				pins.dev_bus_o <= {epp_pkg::CMD_PROGRAM, AFLD_PAD'(0), idx_q};
				pins.dev_bus_oe <= 16'hFFFF;
			end else if (state_q == D_A_DATA) begin
				pins.dev_bus_o <= data_q;
				pins.dev_bus_oe <= 16'hFFFF;
			end
			// Config-byte auto mode also reports failures on verify
			if (state_q == D_A_DATA && cnt_q == 5'(epp_pkg::STROBE_LOW_CYC - 1)
				&& alg_q == epp_pkg::ALG_AUTO_CFG) begin
				pins.dev_verify <= wr_ok;
			end
		end
	end
endmodule // epp_device

// ==== rtl/epp_pkg.sv ====
package epp_pkg;
	localparam int BUS_W = 16;
	localparam int PORT_W = 8;
	localparam int ALG_W = 2;
	localparam int SEL_W = 4;
	localparam int CMD_W = 2;
	localparam int AFLD_W = 14;
	localparam int CMD_LSB = 14;
	// Algorithm codes on the select pins
	localparam logic [1:0] ALG_SLAVE = 2'h0;
	localparam logic [1:0] ALG_AUTO = 2'h1;
	localparam logic [1:0] ALG_AUTO_CFG = 2'h2;
	// Command codes in bus[15:14] of a latch phase
	localparam logic [1:0] CMD_PROGRAM = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	// Pulled-up idle bus and erased cell value
	localparam logic [15:0] BUS_IDLE = 16'hFFFF;
	localparam logic [15:0] ERASED = 16'hFFFF;
	localparam logic [15:0] AUTO_SRC_BASE = 16'h0000;
	// Timing, in ns and in 25 ns cycles
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETUP_NS = 50;
	localparam int STROBE_LOW_NS = 250;
	localparam int ACK_HOLD_NS = 200;
	localparam int RECOVER_NS = 300;
	localparam int SYS_RD_NS = 75;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_HOLD_CYC = (ACK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYS_RD_CYC = (SYS_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALG_SETTLE_CYC = 3;
	localparam int CNT_W = 5;

	// One-time cells only clear bits: success when no 0 must become 1
	function automatic logic program_strobe_ok(input logic [15:0] old_w, input logic [15:0] new_w);
		return (old_w & new_w) == new_w;
	endfunction
endpackage

// ==== rtl/epp_if.sv ====
`timescale 1ns/1ps
interface epp_if;
	logic        program_strobe_latch;
	logic        program_strobe_strobe_n;
	logic        program_strobe_auto_increment_n_n;
	logic [15:0] program_strobe_bus_o;
	logic [15:0] program_strobe_bus_oe;
	logic        dev_latch;
	logic        dev_strobe_n;
	logic        dev_verify;
	logic [15:0] dev_bus_o;
	logic [15:0] dev_bus_oe;
	logic        program_address_latch;
	logic        program_strobe;
	logic        auto_increment_n;
	logic        program_verify;
	logic [15:0] programming_bus;

	// Wire resolution: device wins a clash, pullups give ones
	assign programming_bus = (dev_bus_oe & dev_bus_o) | (~dev_bus_oe & program_strobe_bus_oe & program_strobe_bus_o)
		| (~dev_bus_oe & ~program_strobe_bus_oe);
	assign program_address_latch = program_strobe_latch | dev_latch;
	assign program_strobe = program_strobe_strobe_n & dev_strobe_n;
	assign auto_increment_n = program_strobe_auto_increment_n_n;
	assign program_verify = dev_verify;

	modport device (
		input  program_address_latch, program_strobe, auto_increment_n, programming_bus,
		output dev_latch, dev_strobe_n, dev_verify, dev_bus_o, dev_bus_oe
	);
	modport programmer (
		input  programming_bus, program_verify,
		output program_strobe_latch, program_strobe_strobe_n, program_strobe_auto_increment_n_n, program_strobe_bus_o, program_strobe_bus_oe
	);
endinterface

// ==== rtl/epp_programmer.sv ====
`timescale 1ns/1ps
module epp_programmer #(
	parameter int AW = 6
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	epp_if.programmer          pins,
	input  wire logic [3:0]    slave_ack_pin_select_i,
	input  wire logic          auto_increment_n_en_i,
	input  wire logic          cmd_valid_i,
	output logic               cmd_ready_o,
	input  wire logic          cmd_read_i,
	input  wire logic          cmd_send_addr_i,
	input  wire logic [AW-1:0] cmd_addr_i,
	input  wire logic [15:0]   cmd_data_i,
	output logic               rd_valid_o,
	input  wire logic          rd_ready_i,
	output logic [15:0]        rd_data_o,
	output logic               done_o,
	output logic               verify_ok_o,
	output logic               ack_ok_o
);
	localparam int AFLD_PAD = epp_pkg::AFLD_W - AW;
	typedef enum logic [2:0] {P_IDLE, P_ASET, P_ALOW, P_DSET, P_DLOW, P_REC} epp_pst_t;
	epp_pst_t state_q, state_d;
	logic [4:0]    cnt_q;
	logic          rd_q;
	logic [AW-1:0] addr_q;
	logic [15:0]   data_q;
	logic [15:0]   bus1_q, bus2_q;
	logic          ver1_q, ver2_q;
	logic          last;
	logic          push, pop;
	logic [15:0]   spare_q;
	logic          spare_v_q;

	// Pins come from the slave: two flops before use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus1_q <= epp_pkg::BUS_IDLE;
			bus2_q <= epp_pkg::BUS_IDLE;
			ver1_q <= 1'b1;
			ver2_q <= 1'b1;
		end else if (ce_i) begin
			bus1_q <= pins.programming_bus;
			bus2_q <= bus1_q;
			ver1_q <= pins.program_verify;
			ver2_q <= ver1_q;
		end
	end

	// Phase length reached
	always_comb begin
		case (state_q)
			P_ASET, P_DSET: last = cnt_q == 5'(epp_pkg::SETUP_CYC - 1);
			P_ALOW, P_DLOW: last = cnt_q == 5'(epp_pkg::STROBE_LOW_CYC - 1);
			P_REC:          last = cnt_q == 5'(epp_pkg::RECOVER_CYC - 1);
			default:        last = 1'b0;
		endcase
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			P_IDLE: if (cmd_valid_i && cmd_ready_o) state_d = cmd_send_addr_i ? P_ASET : P_DSET;
			P_ASET: if (last) state_d = P_ALOW;
			P_ALOW: if (last) state_d = P_DSET;
			P_DSET: if (last) state_d = P_DLOW;
			P_DLOW: if (last) state_d = P_REC;
			P_REC:  if (last) state_d = P_IDLE;
			default: state_d = P_IDLE;
		endcase
	end

	// Sequencer and pin drive; latch marks command/address phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= P_IDLE;
			cnt_q <= 5'h00;
			rd_q <= 1'b0;
			addr_q <= '0;
			data_q <= 16'h0000;
			pins.program_strobe_latch <= 1'b0;
			pins.program_strobe_strobe_n <= 1'b1;
			pins.program_strobe_auto_increment_n_n <= 1'b1;
			pins.program_strobe_bus_o <= epp_pkg::BUS_IDLE;
			pins.program_strobe_bus_oe <= 16'h0000;
			cmd_ready_o <= 1'b0;
			done_o <= 1'b0;
			verify_ok_o <= 1'b1;
			ack_ok_o <= 1'b1;
		end else if (ce_i) begin
			state_q <= state_d;
			cnt_q <= (state_d != state_q) ? 5'h00 : cnt_q + 5'h01;
			pins.program_strobe_auto_increment_n_n <= ~auto_increment_n_en_i;
			// Reads wait for buffer room so a stalled reader loses nothing
			cmd_ready_o <= (state_d == P_IDLE) && !spare_v_q;
			done_o <= (state_q == P_REC) && last;
			if (state_q == P_IDLE && cmd_valid_i && cmd_ready_o) begin
				rd_q <= cmd_read_i;
				addr_q <= cmd_addr_i;
				data_q <= cmd_data_i;
			end
			pins.program_strobe_latch <= state_d == P_ASET || state_d == P_ALOW;
			pins.program_strobe_strobe_n <= !(state_d == P_ALOW || state_d == P_DLOW);
			if (state_d == P_ASET || state_d == P_ALOW) begin
				pins.program_strobe_bus_o <= {(rd_q ? epp_pkg::CMD_READ : epp_pkg::CMD_PROGRAM),
					AFLD_PAD'(0), addr_q};
				pins.program_strobe_bus_oe <= 16'hFFFF;
			end else if ((state_d == P_DSET || state_d == P_DLOW) && !rd_q) begin
				pins.program_strobe_bus_o <= data_q;
				pins.program_strobe_bus_oe <= 16'hFFFF;
			end else begin
				pins.program_strobe_bus_o <= epp_pkg::BUS_IDLE;
				pins.program_strobe_bus_oe <= 16'h0000;
			end
			if (state_q == P_IDLE && cmd_valid_i && cmd_ready_o) begin
				rd_q <= cmd_read_i;
			end
			// Verify level and the slave's own ack pin, after the rise
			if (state_q == P_REC && last) begin
				verify_ok_o <= ver2_q;
				ack_ok_o <= bus2_q[slave_ack_pin_select_i];
			end
		end
	end

	// Two-entry buffer: head is the output register, spare absorbs a stall
	assign push = ce_i && rd_q && state_q == P_DLOW && last;
	assign pop = ce_i && rd_valid_o && rd_ready_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o <= 16'h0000;
			spare_q <= 16'h0000;
			spare_v_q <= 1'b0;
		end else if (ce_i) begin
			if (pop && spare_v_q) begin
				rd_data_o <= spare_q;
				spare_v_q <= push;
				if (push) spare_q <= bus2_q;
			end else if (pop) begin
				rd_valid_o <= push;
				if (push) rd_data_o <= bus2_q;
			end else if (push && !rd_valid_o) begin
				rd_valid_o <= 1'b1;
				rd_data_o <= bus2_q;
			end else if (push) begin
				spare_v_q <= 1'b1;
				spare_q <= bus2_q;
			end
		end
	end
endmodule // epp_programmer

// ==== dv/epp_chk.sv ====
`timescale 1ns/1ps
// Watches the shared programming link; both ends are design code
module epp_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        program_strobe_latch_i,
	input wire logic        program_strobe_strobe_n_i,
	input wire logic [15:0] program_strobe_bus_i,
	input wire logic [15:0] program_strobe_bus_oe_i,
	input wire logic        dev_latch_i,
	input wire logic        dev_strobe_n_i,
	input wire logic        dev_verify_i,
	input wire logic [15:0] dev_bus_oe_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Programmer strobe: ten cycles low, then a two-cycle gap before the data phase
	a_strobe_low_span: assert property (
		$fell(program_strobe_strobe_n_i) |-> ##9 !program_strobe_strobe_n_i ##1 program_strobe_strobe_n_i)
		else $error("programmer strobe low span wrong");
	a_strobe_gap_span: assert property (
		$rose(program_strobe_strobe_n_i) |-> program_strobe_strobe_n_i ##1 program_strobe_strobe_n_i)
		else $error("programmer strobe gap too short");
	// Latch phase: full bus driven, latch drops with the strobe rise
	a_latch_drives_bus: assert property (
		$rose(program_strobe_latch_i) |-> program_strobe_bus_oe_i == 16'hFFFF)
		else $error("latch phase without bus drive");
	a_latch_ends_rise: assert property (
		$fell(program_strobe_latch_i) |-> $rose(program_strobe_strobe_n_i))
		else $error("latch dropped off the strobe rise");
	// Data must not move while the strobe is low, else the slave sees a torn word
	a_data_held_low: assert property (
		!program_strobe_strobe_n_i && !$past(program_strobe_strobe_n_i) |-> $stable(program_strobe_bus_i) && $stable(program_strobe_bus_oe_i))
		else $error("bus changed under a low strobe");
	a_dev_quiet_latch: assert property (
		program_strobe_latch_i |-> dev_bus_oe_i == 16'h0000)
		else $error("device drives during a latch phase");
	a_verify_held_op: assert property (
		$fell(program_strobe_strobe_n_i) |=> $stable(dev_verify_i)[*8])
		else $error("verify moved during an operation");
	// Auto mode: device masters the strobe and drives its command
	a_dev_strobe_span: assert property (
		$fell(dev_strobe_n_i) |-> ##8 !dev_strobe_n_i ##1 dev_strobe_n_i)
		else $error("device strobe low span wrong");
	a_dev_cmd_drive: assert property (
		$fell(dev_strobe_n_i) && dev_latch_i |-> dev_bus_oe_i == 16'hFFFF)
		else $error("device command phase not driven");
endmodule // epp_chk

// ==== dv/epp_tb.sv ====
`timescale 1ns/1ps
module epp_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [1:0]  alg_sel = epp_pkg::ALG_SLAVE;
	logic [3:0]  slave_ack_pin_select = 4'h5;
	logic        auto_increment_n_en = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_read = 1'b0;
	logic        cmd_send_addr = 1'b0;
	logic        rd_ready = 1'b0;
	logic        ce = 1'b1;
	logic [5:0]  cmd_addr = 6'h00;
	logic [5:0]  core_addr = 6'h00;
	logic [15:0] cmd_data = 16'h0000;
	logic        cmd_ready, rd_valid, done, verify_ok, ack_ok, sys_rd, active, result;
	logic [15:0] rd_data, core_data;
	int          bad_count = 0;
	int          compares = 0;

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	// Both ends joined across one link; one clock enable freezes both
	epp_if i_epp_if ();
	epp_device #(.AW(6), .AUTO_WORDS(4)) i_epp_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.pins(i_epp_if.device), .algorithm_select_i(alg_sel), .slave_ack_pin_select_i(slave_ack_pin_select),
		.core_rd_addr_i(core_addr), .core_rd_data_o(core_data), .sys_rd_o(sys_rd),
		.programming_active_o(active), .program_result_o(result));
	epp_programmer #(.AW(6)) i_epp_programmer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.pins(i_epp_if.programmer), .slave_ack_pin_select_i(slave_ack_pin_select), .auto_increment_n_en_i(auto_increment_n_en),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
		.cmd_send_addr_i(cmd_send_addr), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
		.rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data), .done_o(done),
		.verify_ok_o(verify_ok), .ack_ok_o(ack_ok));
	epp_chk i_epp_chk (.clk_i(clk_i), .rst_i(rst_i), .program_strobe_latch_i(i_epp_if.program_strobe_latch),
		.program_strobe_strobe_n_i(i_epp_if.program_strobe_strobe_n), .program_strobe_bus_i(i_epp_if.program_strobe_bus_o),
		.program_strobe_bus_oe_i(i_epp_if.program_strobe_bus_oe), .dev_latch_i(i_epp_if.dev_latch),
		.dev_strobe_n_i(i_epp_if.dev_strobe_n), .dev_verify_i(i_epp_if.dev_verify),
		.dev_bus_oe_i(i_epp_if.dev_bus_oe));

	// Counted compare; four-state so an unknown never matches
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Select is set while reset is held and never moved afterwards
	task automatic do_reset(input logic [1:0] alg);
		@(posedge clk_i);
		rst_i <= 1'b1;
		alg_sel <= alg;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask

	// One command: hold valid until taken, then wait for its done pulse
	task automatic send(input logic rd, input logic sa, input logic [5:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_send_addr <= sa;
		cmd_addr <= a;
		cmd_data <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (cmd_ready !== 1'b1 && n < 200);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done !== 1'b1 && n < 200);
		check("command done", 16'h0001, 16'(done));
		repeat (4) @(posedge clk_i);
	endtask

	// Array contents seen from the core side
	task automatic peek(input logic [5:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		core_addr <= a;
		repeat (3) @(posedge clk_i);
		check("cell word", exp, core_data);
	endtask

	task automatic pop(input logic [15:0] exp);
		int n;
		n = 0;
		@(posedge clk_i);
		rd_ready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_valid !== 1'b1 && n < 100);
		check("read word", exp, rd_data);
		rd_ready <= 1'b0;
	endtask

	task automatic t_idle();
		check("active after reset", 16'h0000, 16'(active));
		check("result after reset", 16'h0000, 16'(result));
		check("verify after reset", 16'h0001, 16'(i_epp_if.program_verify));
		check("bus released", 16'hFFFF, i_epp_if.programming_bus);
		check("no read word", 16'h0000, 16'(rd_valid));
		$display("test idle done");
	endtask

	// Pass, refused 0-to-1 change, then a partial clear of the same cell
	task automatic t_program_strobe();
		send(1'b0, 1'b1, 6'h05, 16'hA5C3);
		check("verify pass", 16'h0001, 16'(verify_ok));
		check("ack pass", 16'h0001, 16'(ack_ok));
		peek(6'h05, 16'hA5C3);
		send(1'b0, 1'b1, 6'h05, 16'hFFFF);
		check("verify fail", 16'h0000, 16'(verify_ok));
		check("ack fail", 16'h0000, 16'(ack_ok));
		peek(6'h05, 16'hA5C3);
		send(1'b0, 1'b1, 6'h05, 16'h8181);
		check("verify clear", 16'h0001, 16'(verify_ok));
		peek(6'h05, 16'h8181);
		$display("test program done");
	endtask

	// Second word has no address phase and lands on the top cell
	task automatic t_auto_increment_n();
		slave_ack_pin_select <= 4'h0;
		auto_increment_n_en <= 1'b1;
		send(1'b0, 1'b1, 6'h3E, 16'h1234);
		send(1'b0, 1'b0, 6'h00, 16'h5678);
		check("ack pin zero", 16'h0001, 16'(ack_ok));
		auto_increment_n_en <= 1'b0;
		peek(6'h3E, 16'h1234);
		peek(6'h3F, 16'h5678);
		$display("test increment done");
	endtask

	// Reader stalls: two words held, third command refused, none lost
	task automatic t_buffer();
		send(1'b1, 1'b1, 6'h3E, 16'h0000);
		send(1'b1, 1'b1, 6'h3F, 16'h0000);
		repeat (10) @(posedge clk_i);
		check("ready while full", 16'h0000, 16'(cmd_ready));
		pop(16'h1234);
		pop(16'h5678);
		send(1'b1, 1'b1, 6'h05, 16'h0000);
		pop(16'h8181);
		// The pop lands at the edge the task returns on; look one edge later
		@(posedge clk_i);
		check("buffer empty", 16'h0000, 16'(rd_valid));
		$display("test buffer done");
	endtask

	// Clock enable low: a held command is not taken and nothing moves
	task automatic t_freeze();
		@(posedge clk_i);
		ce <= 1'b0;
		cmd_valid <= 1'b1;
		cmd_read <= 1'b0;
		cmd_send_addr <= 1'b1;
		cmd_addr <= 6'h06;
		cmd_data <= 16'h0000;
		repeat (20) @(posedge clk_i);
		check("latch while frozen", 16'h0000, 16'(i_epp_if.program_address_latch));
		check("ready while frozen", 16'h0001, 16'(cmd_ready));
		cmd_valid <= 1'b0;
		ce <= 1'b1;
		repeat (50) @(posedge clk_i);
		peek(6'h06, 16'hFFFF);
		$display("test freeze done");
	endtask

	// Both auto algorithms over an erased array and a pulled-up source bus
	task automatic t_auto();
		logic [1:0] algs [2];
		logic       seen_rd;
		int         n;
		algs[0] = epp_pkg::ALG_AUTO;
		algs[1] = epp_pkg::ALG_AUTO_CFG;
		for (int i = 0; i < 2; i++) begin
			do_reset(algs[i]);
			seen_rd = 1'b0;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (active !== 1'b1 && n < 50);
			check("auto active", 16'h0001, 16'(active));
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
				seen_rd = seen_rd | (sys_rd === 1'b1);
			end while (active !== 1'b0 && n < 2000);
			check("auto finished", 16'h0000, 16'(active));
			check("auto result", 16'h0000, 16'(result));
			check("source read", 16'h0001, 16'(seen_rd));
			check("auto verify", 16'h0001, 16'(i_epp_if.program_verify));
		end
		do_reset(epp_pkg::ALG_SLAVE);
		$display("test auto done");
	endtask

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		do_reset(epp_pkg::ALG_SLAVE);
		t_idle();
		t_freeze();
		t_program_strobe();
		t_auto_increment_n();
		t_buffer();
		t_auto();
		summarize();
	end

	// Watchdog well beyond the fewer than one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		summarize();
	end
endmodule // epp_tb
